// [motion_partner.sv]
`timescale 1ns/10ps
module motion_partner #(
    parameter int RUN_CYC = 40,
    parameter int STOP_CYC = 4
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic GO,
    input wire logic SOFT_STOP,
    input wire logic RESUME_MOTION,
    output logic MOTION_ACTIVE,
    output logic MOTION_START,
    output logic MOTION_END
);
    int cnt;
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cnt <= 0;
            MOTION_ACTIVE <= 1'b0;
            MOTION_START <= 1'b0;
            MOTION_END <= 1'b0;
        end else begin
            MOTION_START <= GO;
            MOTION_END <= MOTION_ACTIVE && cnt == 1;
            // Resume restarts a full run, simpler than tracking travel
            if (GO || RESUME_MOTION) begin
                MOTION_ACTIVE <= 1'b1;
                cnt <= RUN_CYC;
            end else if (SOFT_STOP && cnt > STOP_CYC) begin
                cnt <= STOP_CYC;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
                MOTION_ACTIVE <= cnt > 1;
            end
        end
    end
endmodule : motion_partner

// [output_signal_router_pause_ctrl.sv]
`timescale 1ns/10ps
module output_signal_router_pause_ctrl #(
    parameter int TEMP_W = 8,
    parameter int POS_W = 24
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ENCODER_PRESENT,
    input wire logic [POS_W-1:0] ENCODER_COUNT,
    input wire logic [POS_W-1:0] COMMAND_POS,
    input wire logic [TEMP_W-1:0] DRIVE_TEMPERATURE,
    input wire logic WARNING_CAUSE,
    input wire logic MOTION_ACTIVE,
    input wire logic MOTION_LINKED,
    input wire logic MOTION_START,
    input wire logic MOTION_END,
    input wire logic PAUSE_PIN,
    input wire logic PAUSE_DISCARD_INPUT,
    output logic SOFT_STOP,
    output logic RESUME_MOTION,
    output logic DISCARD_MOTION,
    output logic WAIT_MOTION_END_RELEASE,
    input wire logic WAIT_MOTION_END,
    output logic [3:0] OUT_PORT
);
    typedef struct packed {
        logic [sigroute_pkg::CFG_W-1:0] cfg_stored;
        logic [sigroute_pkg::CFG_W-1:0] cfg_live;
        logic loaded;
        logic [3:0] gpo;
        logic [POS_W-1:0] stepout_band;
        logic [TEMP_W-1:0] drive_temp_limit;
        logic stepout_flag;
        logic overheat_flag;
        logic warning_flag;
        logic paused_flag;
        logic resumable;
        logic wait_pend;
        logic io_test_mode;
        logic [3:0] test_out;
        logic [3:0] saved_out;
        logic [3:0] out_port;
        logic soft_stop;
        logic resume_motion;
        logic discard;
        logic wait_release;
        logic pause_pin_q;
        logic clr_pin_q;
        logic [31:0] prdata;
    } st_s;
    st_s s_q, s_d;
    logic [1:0] pins_sync;
    pin_sync #(
        .W(2)
    ) u_sync (
        .CORE_CLK(CORE_CLK),
        .RST(RST),
        .d({PAUSE_DISCARD_INPUT, PAUSE_PIN}),
        .q(pins_sync)
    );
    logic wr, rd;
    logic [POS_W-1:0] diff;
    logic [3:0] drive_mask, drive_val, normal_out;
    logic [15:0] sw;
    logic pause_req, clear_req, resume_req;
    assign wr = PSEL && PENABLE && PWRITE;
    // Read data captured in setup, so it stands at the access edge
    assign rd = PSEL && !PENABLE && !PWRITE;
    assign diff = (ENCODER_COUNT >= COMMAND_POS) ? ENCODER_COUNT - COMMAND_POS : COMMAND_POS - ENCODER_COUNT;

    function automatic logic [3:0] route(input logic [sigroute_pkg::SEL_W-1:0] sel);
        logic [3:0] m;
        m = 4'h0;
        // Select zero routes nowhere
        // zero means unassigned
        if (sel >= 3'h1 && sel <= 3'h4) begin
            m[sel[1:0] - 2'h1] = 1'b1;
        end
        return m;
    endfunction : route

    always_comb begin
        logic [3:0] m_sto, m_tmp, m_wng, m_pst;
        logic [sigroute_pkg::CFG_W-1:0] c;
        m_sto = '0;
        m_tmp = '0;
        m_wng = '0;
        m_pst = '0;
        c = s_q.cfg_live;
        m_sto = route(c[sigroute_pkg::STO_SEL_LSB +: 3]);
        m_tmp = route(c[sigroute_pkg::TMP_SEL_LSB +: 3]);
        m_wng = route(c[sigroute_pkg::WNG_SEL_LSB +: 3]);
        m_pst = route(c[sigroute_pkg::PST_SEL_LSB +: 3]);
        drive_mask = m_sto | m_tmp | m_wng | m_pst;
        drive_val = (m_sto & {4{s_q.stepout_flag ^ c[sigroute_pkg::STO_POL_BIT]}})
            | (m_tmp & {4{s_q.overheat_flag ^ c[sigroute_pkg::TMP_POL_BIT]}})
            | (m_wng & {4{s_q.warning_flag ^ c[sigroute_pkg::WNG_POL_BIT]}})
            | (m_pst & {4{s_q.paused_flag ^ c[sigroute_pkg::PST_POL_BIT]}});
        normal_out = (drive_mask & drive_val) | (~drive_mask & s_q.gpo);
    end

    always_comb begin
        sw = '0;
        sw[sigroute_pkg::ST_PAUSE] = s_q.paused_flag;
        sw[sigroute_pkg::ST_TEMP] = s_q.overheat_flag;
        sw[sigroute_pkg::ST_STO] = s_q.stepout_flag;
        sw[sigroute_pkg::ST_WNG] = s_q.warning_flag;
    end

    always_comb begin
        logic pp, cp;
        pp = 1'b0;
        cp = 1'b0;
        s_d = s_q;
        s_d.soft_stop = 1'b0;
        s_d.resume_motion = 1'b0;
        s_d.discard = 1'b0;
        s_d.wait_release = 1'b0;
        s_d.pause_pin_q = pins_sync[0];
        s_d.clr_pin_q = pins_sync[1];
        // Pins only act when assigned and not under test
        // pause pin edge
        pp = pins_sync[0] && !s_q.pause_pin_q && s_q.cfg_live[sigroute_pkg::PAUSE_IN_BIT] && !s_q.io_test_mode;
        cp = pins_sync[1] && !s_q.clr_pin_q && s_q.cfg_live[sigroute_pkg::CLR_IN_BIT] && !s_q.io_test_mode;
        pause_req = pp || (wr && PADDR == sigroute_pkg::CMD_OFS && PWDATA[sigroute_pkg::CMD_PAUSE]);
        clear_req = cp || (wr && PADDR == sigroute_pkg::CMD_OFS && PWDATA[sigroute_pkg::CMD_CLEAR]);
        resume_req = wr && PADDR == sigroute_pkg::CMD_OFS && PWDATA[sigroute_pkg::CMD_RESUME];
        // live copy taken once after reset
        if (!s_q.loaded) begin
            s_d.cfg_live = s_q.cfg_stored;
            s_d.loaded = 1'b1;
        end
        s_d.stepout_flag = ENCODER_PRESENT && s_q.cfg_live[sigroute_pkg::STEPOUT_DETECT_ENABLE_BIT] && diff >= s_q.stepout_band;
        if (DRIVE_TEMPERATURE > s_q.drive_temp_limit) begin
            s_d.overheat_flag = 1'b1;
        end else if (DRIVE_TEMPERATURE < s_q.drive_temp_limit) begin
            s_d.overheat_flag = 1'b0;
        end
        s_d.warning_flag = WARNING_CAUSE;
        if (WAIT_MOTION_END && !s_q.wait_pend) begin
            s_d.wait_pend = 1'b1;
        end
        // release here only on a real motion end; a discard below also releases
        if ((s_q.wait_pend || WAIT_MOTION_END) && MOTION_END && !s_q.paused_flag) begin
            s_d.wait_pend = 1'b0;
            s_d.wait_release = 1'b1;
        end
        if (MOTION_START) begin
            s_d.paused_flag = 1'b0;
            s_d.resumable = 1'b0;
        end
        if (pause_req && MOTION_ACTIVE) begin
            s_d.soft_stop = 1'b1;
            if (!MOTION_LINKED) begin
                s_d.paused_flag = 1'b1;
                s_d.resumable = 1'b1;
            end
        end else if (clear_req && s_q.paused_flag) begin
            s_d.paused_flag = 1'b0;
            s_d.resumable = 1'b0;
            s_d.discard = 1'b1;
            if (s_q.wait_pend || WAIT_MOTION_END) begin
                s_d.wait_pend = 1'b0;
                s_d.wait_release = 1'b1;
            end
        end else if (resume_req && s_q.resumable && !MOTION_START) begin
            s_d.paused_flag = 1'b0;
            s_d.resumable = 1'b0;
            s_d.resume_motion = 1'b1;
        end
        if (wr) begin
            unique case (PADDR)
                sigroute_pkg::CFG_OFS: s_d.cfg_stored = PWDATA[sigroute_pkg::CFG_W-1:0];
                sigroute_pkg::GPO_OFS: begin
                    if (!s_q.io_test_mode) begin
                        s_d.gpo = PWDATA[3:0];
                    end
                end
                sigroute_pkg::BAND_OFS: s_d.stepout_band = PWDATA[POS_W-1:0];
                sigroute_pkg::TLIM_OFS: s_d.drive_temp_limit = PWDATA[TEMP_W-1:0];
                sigroute_pkg::CMD_OFS: begin
                    if (PWDATA[sigroute_pkg::CMD_TEST_ENTER] && !s_q.io_test_mode) begin
                        s_d.io_test_mode = 1'b1;
                        s_d.saved_out = s_q.out_port;
                        s_d.test_out = s_q.out_port;
                    end
                end
                sigroute_pkg::TEST_OFS: begin
                    if (s_q.io_test_mode) begin
                        if (PWDATA[sigroute_pkg::KEY_ESC]) begin
                            s_d.io_test_mode = 1'b0;
                        end else if (PWDATA[sigroute_pkg::KEY_SPACE]) begin
                            s_d.test_out = 4'h0;
                        end else begin
                            s_d.test_out = s_q.test_out ^ PWDATA[3:0];
                        end
                    end
                end
                default: ;
            endcase
        end
        if (s_q.io_test_mode && !s_d.io_test_mode) begin
            s_d.out_port = s_q.saved_out;
        end else if (s_d.io_test_mode) begin
            s_d.out_port = s_d.test_out;
        end else begin
            s_d.out_port = normal_out;
        end
        s_d.prdata = 32'h0;
        if (rd) begin
            unique case (PADDR)
                sigroute_pkg::CFG_OFS: s_d.prdata = 32'(s_q.cfg_stored);
                sigroute_pkg::GPO_OFS: s_d.prdata = {28'h0, s_q.gpo};
                sigroute_pkg::BAND_OFS: s_d.prdata = 32'(s_q.stepout_band);
                sigroute_pkg::TLIM_OFS: s_d.prdata = 32'(s_q.drive_temp_limit);
                sigroute_pkg::STAT_OFS: s_d.prdata = {16'h0, sw};
                sigroute_pkg::ACTIVE_OFS: s_d.prdata = 32'(s_q.cfg_live);
                sigroute_pkg::TEST_OFS: s_d.prdata = {23'h0, s_q.io_test_mode, 2'h0, pins_sync, s_q.out_port};
                default: s_d.prdata = 32'h0;
            endcase
        end
        // system reset reloads live config
        // Stored selects survive it, standing in for persistent storage
        if (wr && PADDR == sigroute_pkg::CMD_OFS && PWDATA[sigroute_pkg::CMD_SYS_RESET]) begin
            s_d = '0;
            s_d.cfg_stored = s_q.cfg_stored;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign SOFT_STOP = s_q.soft_stop;
    assign RESUME_MOTION = s_q.resume_motion;
    assign DISCARD_MOTION = s_q.discard;
    assign WAIT_MOTION_END_RELEASE = s_q.wait_release;
    assign OUT_PORT = s_q.out_port;
endmodule : output_signal_router_pause_ctrl

// [output_signal_router_pause_ctrl_properties.sv]
`timescale 1ns/10ps
module router_props (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic WARNING_CAUSE,
    input wire logic MOTION_ACTIVE,
    input wire logic MOTION_END,
    input wire logic SOFT_STOP,
    input wire logic RESUME_MOTION,
    input wire logic DISCARD_MOTION,
    input wire logic WAIT_MOTION_END_RELEASE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic rd;
    assign rd = PSEL && PENABLE && !PWRITE;
    a_bus_answer: assert property (PREADY && !PSLVERR) else $error("bus answer wrong");
    a_unmapped_zero: assert property (rd && PADDR > 8'h1C |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_stop_once: assert property (SOFT_STOP |=> !SOFT_STOP) else $error("stop pulse long");
    a_resume_once: assert property (RESUME_MOTION |=> !RESUME_MOTION) else $error("resume long");
    a_discard_once: assert property (DISCARD_MOTION |=> !DISCARD_MOTION) else $error("discard long");
    a_idle_no_stop: assert property (!MOTION_ACTIVE [*2] |-> !SOFT_STOP) else $error("stop when idle");
    a_stop_needs_run: assert property (SOFT_STOP |-> $past(MOTION_ACTIVE)) else $error("stop without motion");
    a_release_cause: assert property (WAIT_MOTION_END_RELEASE |-> $past(MOTION_END) || DISCARD_MOTION)
        else $error("release without end");
    a_warn_status: assert property (rd && PADDR == sigroute_pkg::STAT_OFS |->
        PRDATA[sigroute_pkg::ST_WNG] == $past(WARNING_CAUSE, 2))
        else $error("warning bit wrong");
endmodule : router_props

// [output_signal_router_pause_ctrl_tb.sv]
`timescale 1ns/10ps
module output_signal_router_pause_ctrl_tb;
    logic clk, rst, psel, pen, pwr, prdy, perr, warn, act, link, st, en, stop, res, disc, rel, wte, go;
    logic enc, ppin, cpin;
    logic [7:0] padr, temp;
    logic [23:0] ecnt, cpos;
    logic [31:0] pwd, prd, rd;
    logic [3:0] outp;
    int miscompares = 0, n_tests = 0, cyc = 0, n_stop = 0, n_res = 0, n_disc = 0, n_rel = 0;
    output_signal_router_pause_ctrl output_signal_router_pause_ctrl_inst (.CORE_CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .ENCODER_PRESENT(enc), .ENCODER_COUNT(ecnt), .COMMAND_POS(cpos),
        .DRIVE_TEMPERATURE(temp), .WARNING_CAUSE(warn), .MOTION_ACTIVE(act), .MOTION_LINKED(link),
        .MOTION_START(st), .MOTION_END(en), .PAUSE_PIN(ppin), .PAUSE_DISCARD_INPUT(cpin), .SOFT_STOP(stop),
        .RESUME_MOTION(res), .DISCARD_MOTION(disc), .WAIT_MOTION_END_RELEASE(rel), .WAIT_MOTION_END(wte),
        .OUT_PORT(outp));
    motion_partner motion_partner_inst (.CORE_CLK(clk), .RST(rst), .GO(go), .SOFT_STOP(stop),
        .RESUME_MOTION(res), .MOTION_ACTIVE(act), .MOTION_START(st), .MOTION_END(en));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_stop <= n_stop + stop;
        n_res <= n_res + res;
        n_disc <= n_disc + disc;
        n_rel <= n_rel + rel;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        // Read data stands only in the access cycle
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer
    task automatic wr(logic [7:0] a, logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rchk(string name, logic [7:0] a, logic [31:0] m, logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(name, e, rd & m);
    endtask : rchk
    task automatic settle(int n);
        repeat (n) @(negedge clk);
    endtask : settle
    task automatic move;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : move
    task automatic t_regs;
        rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        wr(sigroute_pkg::CFG_OFS, 32'h80);
        rchk("stored cfg", sigroute_pkg::CFG_OFS, 32'hFFFFFFFF, 32'h80);
        rchk("live cfg", sigroute_pkg::ACTIVE_OFS, 32'hFFFFFFFF, 32'h0);
    endtask : t_regs
    task automatic t_status;
        wr(sigroute_pkg::GPO_OFS, 32'hA);
        wr(sigroute_pkg::TLIM_OFS, 32'h50);
        @(posedge clk);
        temp <= 8'h51;
        warn <= 1'b1;
        settle(4);
        chk("pins", 32'hA, outp);
        rchk("status", sigroute_pkg::STAT_OFS, 32'h360, 32'h240);
        @(posedge clk);
        temp <= 8'h4F;
        warn <= 1'b0;
        settle(4);
        rchk("status", sigroute_pkg::STAT_OFS, 32'h360, 32'h0);
    endtask : t_status
    task automatic t_pause(logic lk);
        int s;
        int r;
        int rl;
        s = n_stop;
        r = n_res;
        rl = n_rel;
        wr(sigroute_pkg::CMD_OFS, 32'h1);
        settle(3);
        chk("idle stop", s, n_stop);
        @(posedge clk);
        link <= lk;
        wte <= !lk;
        @(posedge clk);
        wte <= 1'b0;
        move();
        wr(sigroute_pkg::CMD_OFS, 32'h1);
        settle(10);
        chk("soft stop", s + 1, n_stop);
        rchk("paused", sigroute_pkg::STAT_OFS, 32'h20, lk ? 32'h0 : 32'h20);
        chk("release", rl, n_rel);
        wr(sigroute_pkg::CMD_OFS, 32'h2);
        settle(3);
        chk("resume", lk ? r : r + 1, n_res);
        rchk("paused", sigroute_pkg::STAT_OFS, 32'h20, 32'h0);
        settle(45);
        chk("release", lk ? rl : rl + 1, n_rel);
        @(posedge clk);
        link <= 1'b0;
    endtask : t_pause
    task automatic t_clear;
        int d;
        int r;
        int rl;
        d = n_disc;
        r = n_res;
        rl = n_rel;
        wr(sigroute_pkg::CMD_OFS, 32'h4);
        settle(2);
        chk("idle discard", d, n_disc);
        @(posedge clk);
        wte <= 1'b1;
        @(posedge clk);
        wte <= 1'b0;
        move();
        wr(sigroute_pkg::CMD_OFS, 32'h1);
        settle(8);
        chk("release", rl, n_rel);
        wr(sigroute_pkg::CMD_OFS, 32'h4);
        settle(2);
        chk("discard", d + 1, n_disc);
        chk("release", rl + 1, n_rel);
        rchk("paused", sigroute_pkg::STAT_OFS, 32'h20, 32'h0);
        wr(sigroute_pkg::CMD_OFS, 32'h2);
        settle(3);
        chk("resume", r, n_res);
    endtask : t_clear
    task automatic t_test;
        wr(sigroute_pkg::CMD_OFS, 32'h8);
        rchk("test", sigroute_pkg::TEST_OFS, 32'h100, 32'h100);
        wr(sigroute_pkg::TEST_OFS, 32'h5);
        settle(1);
        chk("pins", 32'hF, outp);
        wr(sigroute_pkg::GPO_OFS, 32'h0);
        settle(1);
        chk("pins", 32'hF, outp);
        rchk("test pins", sigroute_pkg::TEST_OFS, 32'hF, 32'hF);
        wr(sigroute_pkg::TEST_OFS, 32'h10);
        settle(1);
        chk("pins", 32'h0, outp);
        wr(sigroute_pkg::TEST_OFS, 32'h20);
        settle(1);
        chk("pins", 32'hA, outp);
        settle(3);
        chk("pins", 32'hA, outp);
        rchk("test", sigroute_pkg::TEST_OFS, 32'h100, 32'h0);
    endtask : t_test
    task automatic t_route;
        wr(sigroute_pkg::CFG_OFS, 32'h71891);
        wr(sigroute_pkg::CMD_OFS, 32'h10);
        rchk("live cfg", sigroute_pkg::ACTIVE_OFS, 32'hFFFFFFFF, 32'h71891);
        wr(sigroute_pkg::TLIM_OFS, 32'h50);
        wr(sigroute_pkg::BAND_OFS, 32'h8);
        wr(sigroute_pkg::GPO_OFS, 32'hF);
        settle(2);
        chk("pins", 32'h5, outp);
        @(posedge clk);
        warn <= 1'b1;
        enc <= 1'b1;
        ecnt <= 24'h10;
        cpos <= 24'h20;
        settle(3);
        chk("pins", 32'h6, outp);
        chk("stepout pin", 32'h0, {31'h0, outp[0]});
        rchk("status", sigroute_pkg::STAT_OFS, 32'h360, 32'h300);
        move();
        @(posedge clk);
        ppin <= 1'b1;
        settle(6);
        chk("pins", 32'hE, outp);
        rchk("status", sigroute_pkg::STAT_OFS, 32'h360, 32'h320);
        @(posedge clk);
        ppin <= 1'b0;
        cpin <= 1'b1;
        settle(6);
        chk("pins", 32'h6, outp);
        @(posedge clk);
        cpin <= 1'b0;
        warn <= 1'b0;
        enc <= 1'b0;
    endtask : t_route
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, warn, link, wte, go, enc, ppin, cpin} = '0;
        ecnt = 24'h0;
        cpos = 24'h0;
        padr = 8'h0;
        pwd = 32'h0;
        temp = 8'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_status();
        t_pause(1'b0);
        t_pause(1'b1);
        t_clear();
        t_test();
        t_route();
        print_verdict();
    end
endmodule : output_signal_router_pause_ctrl_tb
bind output_signal_router_pause_ctrl router_props router_props_inst (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WARNING_CAUSE(WARNING_CAUSE), .MOTION_ACTIVE(MOTION_ACTIVE), .MOTION_END(MOTION_END),
    .SOFT_STOP(SOFT_STOP), .RESUME_MOTION(RESUME_MOTION), .DISCARD_MOTION(DISCARD_MOTION),
    .WAIT_MOTION_END_RELEASE(WAIT_MOTION_END_RELEASE));

// [pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;
    sync_s r_q, r_d;
    always_comb begin
        r_d = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign q = r_q.s2;
endmodule : pin_sync

// [sigroute_pkg.sv]
package sigroute_pkg;
    // APB register byte offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] GPO_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS = 8'h08;
    localparam logic [7:0] BAND_OFS = 8'h0C;
    localparam logic [7:0] TLIM_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam logic [7:0] ACTIVE_OFS = 8'h18;
    localparam logic [7:0] TEST_OFS = 8'h1C;
    // Config field positions (staged assignment selects, polarities and enable bits)
    localparam int STO_SEL_LSB = 0;
    localparam int TMP_SEL_LSB = 3;
    localparam int WNG_SEL_LSB = 6;
    localparam int PST_SEL_LSB = 9;
    localparam int STO_POL_BIT = 12;
    localparam int TMP_POL_BIT = 13;
    localparam int WNG_POL_BIT = 14;
    localparam int PST_POL_BIT = 15;
    localparam int STEPOUT_DETECT_ENABLE_BIT = 16;
    localparam int PAUSE_IN_BIT = 17;
    localparam int CLR_IN_BIT = 18;
    localparam int CFG_W = 19;
    localparam logic [CFG_W-1:0] CFG_RESET = '0;
    // Command bits
    localparam int CMD_PAUSE = 0;
    localparam int CMD_RESUME = 1;
    localparam int CMD_CLEAR = 2;
    localparam int CMD_TEST_ENTER = 3;
    localparam int CMD_SYS_RESET = 4;
    // Test key bits (TEST register write)
    localparam int KEY_SPACE = 4;
    localparam int KEY_ESC = 5;
    // Status word bit positions
    localparam int ST_PAUSE = 5;
    localparam int ST_TEMP = 6;
    localparam int ST_STO = 8;
    localparam int ST_WNG = 9;
    localparam int NPORT = 4;
    localparam int SEL_W = 3;
endpackage : sigroute_pkg
